/* File: hdl/mmid_bank.v */
// memory-model identification register bank with read trap checks
`timescale 1ns/1ps
`default_nettype none
`include "mmid_regs.vh"

module mmid_bank #(
  parameter [63:0] REG2_VALUE = `MMID_REG2_DEFAULT // third register value
) (
  input  wire        clk_sys_i,      // core clock, 10 MHz
  input  wire        rst_i,          // async reset, active high
  input  wire        rd_req_i,       // read request, one-cycle pulse
  input  wire [1:0]  rd_op0_i,       // encoding op0
  input  wire [2:0]  rd_op1_i,       // encoding op1
  input  wire [3:0]  rd_crn_i,       // encoding crn
  input  wire [3:0]  rd_crm_i,       // encoding crm
  input  wire [2:0]  rd_op2_i,       // encoding op2
  input  wire [1:0]  current_exception_level_i,           // issuing level
  input  wire        hypervisor_level_active_i,           // level enabled
  input  wire        hypervisor_general_exception_route_i, // route bit
  input  wire        hypervisor_id_group_trap_i,          // trap bit
  output reg         rd_done_o,      // answer valid, one-cycle pulse
  output reg  [63:0] rd_data_o,      // read value, zero on trap
  output reg         rd_hit_o,       // encoding named a bank register
  output reg         trap_o,         // answer is a trap
  output reg  [1:0]  trap_level_o,   // level that takes the trap
  output reg  [5:0]  trap_class_o    // trap class code
);

  // read path in short: the encoding picks a slot, the level check
  // decides return or trap, and one clock later the answer appears.
  // the two fixed registers are pure constants built from nibbles;
  // the third comes in whole through a parameter.
  // nothing but the answer registers holds state, so a read can
  // never disturb anything else in the core.
  // a miss answers with no data and no trap; the pipeline decides
  // what an unknown encoding means.
  // answer fields hold until the next request, so a slow consumer
  // may look at them late; only the strobe is a single pulse.
  // the check runs in the same cycle as the request, which keeps
  // the answer latency fixed at one clock for every level.

  // widths of the read path; fixed by the register format
  localparam       FIELD_W = 4;
  localparam       REG_W   = 64;
  localparam       LEVEL_W = 2;
  localparam       CLASS_W = 6;
  localparam [1:0] NUM_REG = 2'h3;  // slots 0..2 hold registers

  // four-bit field placed at a low bit position
  function [REG_W-1:0] fld;
    input [FIELD_W-1:0] val;
    input integer       pos;
    begin
      fld = {{(REG_W-FIELD_W){1'b0}}, val} << pos;
    end
  endfunction

  // reserved bits of the two fixed registers; forced low whatever a
  // field constant says, so a slip in a value cannot leak upward
  localparam [63:0] RSVD_ZERO = 64'hFFFFF000000F0000;
  localparam [63:0] RSVD_ONE  = 64'hFFFFFFFF00000000;

  // register zero fields
  wire [FIELD_W-1:0] granule_small_stage_two;   // 4KB, stage two
  wire [FIELD_W-1:0] granule_large_stage_two;   // 64KB, stage two
  wire [FIELD_W-1:0] granule_medium_stage_two;  // 16KB, stage two
  wire [FIELD_W-1:0] granule_small;             // 4KB, stage one
  wire [FIELD_W-1:0] granule_large;             // 64KB, stage one
  wire [FIELD_W-1:0] granule_medium;            // 16KB, stage one
  wire [FIELD_W-1:0] secure_memory_split;       // secure split
  wire [FIELD_W-1:0] mixed_endian_support;      // endianness bits
  wire [FIELD_W-1:0] address_space_id_width;    // id width code
  wire [FIELD_W-1:0] physical_address_width;    // address range code

  // register one fields
  wire [FIELD_W-1:0] stage_two_exec_never_split;        // user/kernel
  wire [FIELD_W-1:0] speculative_error_report;          // spec abort
  wire [FIELD_W-1:0] privileged_access_never_support;   // access never
  wire [FIELD_W-1:0] limited_ordering_regions_support;  // ordering
  wire [FIELD_W-1:0] hierarchical_perm_disable_support; // perm disable
  wire [FIELD_W-1:0] virtualization_host_ext;           // host ext
  wire [FIELD_W-1:0] virtual_machine_id_width;          // vm id width
  wire [FIELD_W-1:0] hardware_flag_update_support;      // flag update

  // stage two: code two means supported for stage-two walks
  assign granule_small_stage_two  = `MMID_V0_GRAN_STAGE2;
  assign granule_large_stage_two  = `MMID_V0_GRAN_STAGE2;
  assign granule_medium_stage_two = `MMID_V0_GRAN_STAGE2;
  // stage one: code zero means supported, not absent
  assign granule_small            = `MMID_V0_GRAN_SMALL;
  assign granule_large            = `MMID_V0_GRAN_LARGE;
  // stage one 16KB uses code one for supported
  assign granule_medium           = `MMID_V0_GRAN_MED;
  // secure and non-secure memory are told apart
  assign secure_memory_split      = `MMID_V0_SEC_SPLIT;
  // both endianness control bits are configurable
  assign mixed_endian_support     = `MMID_V0_MIX_ENDIAN;
  // sixteen address space id bits
  assign address_space_id_width   = `MMID_V0_ASID_WIDTH;
  // forty physical address bits, one terabyte
  assign physical_address_width   = `MMID_V0_PA_WIDTH;

  // execute-never at stage two tells user from kernel
  assign stage_two_exec_never_split        = `MMID_V1_XN_SPLIT;
  // no error interrupt from a speculative read abort
  assign speculative_error_report          = `MMID_V1_SPEC_ERR;
  // feature plus the checked translation instructions
  assign privileged_access_never_support   = `MMID_V1_PAN;
  // limited ordering regions present
  assign limited_ordering_regions_support  = `MMID_V1_LOR;
  // hierarchy disable; descriptor bits 62:59 left to hardware
  assign hierarchical_perm_disable_support = `MMID_V1_HPD;
  // host extension present
  assign virtualization_host_ext           = `MMID_V1_VHE;
  // sixteen virtual machine id bits
  assign virtual_machine_id_width          = `MMID_V1_VMID_WIDTH;
  // hardware updates access flag and dirty state
  assign hardware_flag_update_support      = `MMID_V1_HW_FLAGS;

  // fields placed at their positions; the rest is reserved
  wire [REG_W-1:0] reg_zero_raw =
      fld(granule_small_stage_two,  `MMID_F0_GRAN_SMALL2) |
      fld(granule_large_stage_two,  `MMID_F0_GRAN_LARGE2) |
      fld(granule_medium_stage_two, `MMID_F0_GRAN_MED2)   |
      fld(granule_small,            `MMID_F0_GRAN_SMALL)  |
      fld(granule_large,            `MMID_F0_GRAN_LARGE)  |
      fld(granule_medium,           `MMID_F0_GRAN_MED)    |
      fld(secure_memory_split,      `MMID_F0_SEC_SPLIT)   |
      fld(mixed_endian_support,     `MMID_F0_MIX_ENDIAN)  |
      fld(address_space_id_width,   `MMID_F0_ASID_WIDTH)  |
      fld(physical_address_width,   `MMID_F0_PA_WIDTH);
  wire [REG_W-1:0] reg_one_raw =
      fld(stage_two_exec_never_split,        `MMID_F1_XN_SPLIT)   |
      fld(speculative_error_report,          `MMID_F1_SPEC_ERR)   |
      fld(privileged_access_never_support,   `MMID_F1_PAN)        |
      fld(limited_ordering_regions_support,  `MMID_F1_LOR)        |
      fld(hierarchical_perm_disable_support, `MMID_F1_HPD)        |
      fld(virtualization_host_ext,           `MMID_F1_VHE)        |
      fld(virtual_machine_id_width,          `MMID_F1_VMID_WIDTH) |
      fld(hardware_flag_update_support,      `MMID_F1_HW_FLAGS);

  wire [REG_W-1:0] reg_zero = reg_zero_raw & ~RSVD_ZERO;
  wire [REG_W-1:0] reg_one  = reg_one_raw  & ~RSVD_ONE;

  // shared encoding prefix of the memory-model group
  function enc_is_mem;
    input [1:0] op0;
    input [2:0] op1;
    input [3:0] crn;
    input [3:0] crm;
    begin
      enc_is_mem = (op0 == `MMID_OP0_ID) && (op1 == `MMID_OP1_ID) &&
                   (crn == `MMID_CRN_ID) && (crm == `MMID_CRM_MEM);
    end
  endfunction

  // op2 to register slot; slot three stands for no register here
  function [1:0] slot_of;
    input [2:0] op2;
    begin
      case (op2)
        `MMID_OP2_ZERO: begin
          slot_of = 2'h0;
        end
        `MMID_OP2_ONE: begin
          slot_of = 2'h1;
        end
        `MMID_OP2_TWO: begin
          slot_of = 2'h2;
        end
        default: begin
          slot_of = 2'h3;
        end
      endcase
    end
  endfunction

  wire       enc_id = enc_is_mem(rd_op0_i, rd_op1_i, rd_crn_i, rd_crm_i);
  wire [1:0] slot   = slot_of(rd_op2_i);

  // slot three is outside the bank, a miss rather than a trap
  wire       slot_ok = (slot < NUM_REG);

  reg             hit;
  reg [REG_W-1:0] sel_value;

  // third register included so its reads pass the same check
  always @* begin
    hit       = 1'b0;
    sel_value = 64'h0000000000000000;
    if (enc_id && slot_ok) begin
      hit = 1'b1;
      case (slot)
        2'h0: begin
          sel_value = reg_zero;
        end
        2'h1: begin
          sel_value = reg_one;
        end
        2'h2: begin
          sel_value = REG2_VALUE;
        end
        default: begin
          hit       = 1'b0;
          sel_value = 64'h0000000000000000;
        end
      endcase
    end
  end

  wire               chk_trap;
  wire [LEVEL_W-1:0] chk_level;

  // the check sees only the level and the three hypervisor inputs
  mmid_access_check u_check (
    .level_i      (current_exception_level_i),
    .hyp_active_i (hypervisor_level_active_i),
    .route_i      (hypervisor_general_exception_route_i),
    .id_trap_i    (hypervisor_id_group_trap_i),
    .trap_o       (chk_trap),
    .target_o     (chk_level)
  );

  // a miss never traps, even from user level
  wire take_trap = hit && chk_trap;

  reg               next_done;
  reg [REG_W-1:0]   next_data;
  reg               next_hit;
  reg               next_trap;
  reg [LEVEL_W-1:0] next_level;
  reg [CLASS_W-1:0] next_class;

  // answer fields hold between requests; only a request moves them
  always @* begin
    next_done = rd_req_i;
    next_hit  = rd_hit_o;
    next_data = rd_data_o;
    if (rd_req_i) begin
      next_hit = hit;
      // a trapped read must not leak the value
      if (take_trap) begin
        next_data = 64'h0000000000000000;
      end else begin
        next_data = sel_value;
      end
    end
  end

  // trap code, taker and class follow the check of this request
  always @* begin
    next_trap  = trap_o;
    next_level = trap_level_o;
    next_class = trap_class_o;
    if (rd_req_i) begin
      if (take_trap) begin
        next_trap  = 1'b1;
        next_level = chk_level;
        next_class = `MMID_TRAP_CLASS;
      end else begin
        next_trap  = 1'b0;
        next_level = 2'h0;
        next_class = 6'h00;
      end
    end
  end

  // answer registered one cycle after the request; no other state
  // answer strobe, one cycle per taken request
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rd_done_o <= 1'b0;
    end else begin
      rd_done_o <= next_done;
    end
  end

  // read value, zero after reset and on trap or miss
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rd_data_o <= 64'h0000000000000000;
    end else begin
      rd_data_o <= next_data;
    end
  end

  // hit flag of the last request
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rd_hit_o <= 1'b0;
    end else begin
      rd_hit_o <= next_hit;
    end
  end

  // trap flag of the last request
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      trap_o <= 1'b0;
    end else begin
      trap_o <= next_trap;
    end
  end

  // level that takes the trap, zero when none
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      trap_level_o <= 2'h0;
    end else begin
      trap_level_o <= next_level;
    end
  end

  // class code of the trap, zero when none
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      trap_class_o <= 6'h00;
    end else begin
      trap_class_o <= next_class;
    end
  end

endmodule
`default_nettype wire

/* File: include/mmid_regs.vh */
// constants for the memory-model identification register bank
`ifndef MMID_REGS_VH
`define MMID_REGS_VH

// system register encoding fields (op0, op1, crn, crm, op2)
`define MMID_OP0_ID          2'h3
`define MMID_OP1_ID          3'h0
`define MMID_CRN_ID          4'h0
`define MMID_CRM_ISA         4'h6
`define MMID_CRM_MEM         4'h7
`define MMID_OP2_ZERO        3'h0
`define MMID_OP2_ONE         3'h1
`define MMID_OP2_TWO         3'h2

// exception levels
`define MMID_EL_USER         2'h0
`define MMID_EL_KERNEL       2'h1
`define MMID_EL_HYP          2'h2
`define MMID_EL_MON          2'h3

// trap class code for identification reads
`define MMID_TRAP_CLASS      6'h18

// register zero field positions (low bit)
`define MMID_F0_GRAN_SMALL2  40
`define MMID_F0_GRAN_LARGE2  36
`define MMID_F0_GRAN_MED2    32
`define MMID_F0_GRAN_SMALL   28
`define MMID_F0_GRAN_LARGE   24
`define MMID_F0_GRAN_MED     20
`define MMID_F0_SEC_SPLIT    12
`define MMID_F0_MIX_ENDIAN   8
`define MMID_F0_ASID_WIDTH   4
`define MMID_F0_PA_WIDTH     0

// register zero field values
`define MMID_V0_GRAN_STAGE2  4'h2
`define MMID_V0_GRAN_SMALL   4'h0
`define MMID_V0_GRAN_LARGE   4'h0
`define MMID_V0_GRAN_MED     4'h1
`define MMID_V0_SEC_SPLIT    4'h1
`define MMID_V0_MIX_ENDIAN   4'h1
`define MMID_V0_ASID_WIDTH   4'h2
`define MMID_V0_PA_WIDTH     4'h2

// register one field positions (low bit)
`define MMID_F1_XN_SPLIT     28
`define MMID_F1_SPEC_ERR     24
`define MMID_F1_PAN          20
`define MMID_F1_LOR          16
`define MMID_F1_HPD          12
`define MMID_F1_VHE          8
`define MMID_F1_VMID_WIDTH   4
`define MMID_F1_HW_FLAGS     0

// register one field values
`define MMID_V1_XN_SPLIT     4'h1
`define MMID_V1_SPEC_ERR     4'h0
`define MMID_V1_PAN          4'h2
`define MMID_V1_LOR          4'h1
`define MMID_V1_HPD          4'h2
`define MMID_V1_VHE          4'h1
`define MMID_V1_VMID_WIDTH   4'h2
`define MMID_V1_HW_FLAGS     4'h2

// default value only for register two; field values are a parameter
`define MMID_REG2_DEFAULT    64'h0000000000000000

`endif

/* File: hdl/mmid_access_check.v */
// access check: decides return versus trap for an identification read
`timescale 1ns/1ps
`default_nettype none
`include "mmid_regs.vh"

module mmid_access_check (
  input  wire [1:0] level_i,        // current exception level
  input  wire       hyp_active_i,   // hypervisor level enabled
  input  wire       route_i,        // general exception route bit
  input  wire       id_trap_i,      // identification group trap bit
  output reg        trap_o,         // read must trap
  output reg  [1:0] target_o        // level that takes the trap
);

  always @* begin
    trap_o   = 1'b0;
    target_o = `MMID_EL_KERNEL;
    case (level_i)
      `MMID_EL_USER: begin
        // user reads always trap; route chooses the taker when the hypervisor level is active
        trap_o = 1'b1;
        if (hyp_active_i && route_i) begin
          target_o = `MMID_EL_HYP;
        end
      end
      `MMID_EL_KERNEL: begin
        if (hyp_active_i && id_trap_i) begin
          trap_o   = 1'b1;
          target_o = `MMID_EL_HYP;
        end
      end
      default: begin
        // hypervisor and monitor never trap
        trap_o   = 1'b0;
        target_o = `MMID_EL_KERNEL;
      end
    endcase
  end

endmodule
`default_nettype wire

/* File: dv/mmid_bank_assertions.sv */
// checker for the identification register bank
`timescale 1ns/1ps
`default_nettype none
module mmid_bank_checker (
  input wire logic        clk_sys_i,                  // clock
  input wire logic        rst_i,                      // reset
  input wire logic        rd_req_i,                   // request
  input wire logic [1:0]  rd_op0_i,                   // op0
  input wire logic [2:0]  rd_op1_i,                   // op1
  input wire logic [3:0]  rd_crn_i,                   // crn
  input wire logic [3:0]  rd_crm_i,                   // crm
  input wire logic [2:0]  rd_op2_i,                   // op2
  input wire logic [1:0]  current_exception_level_i,  // level
  input wire logic        hypervisor_level_active_i,  // active
  input wire logic        hypervisor_general_exception_route_i, // route
  input wire logic        hypervisor_id_group_trap_i, // trap bit
  input wire logic        rd_done_o,                  // answer
  input wire logic [63:0] rd_data_o,                  // data
  input wire logic        rd_hit_o,                   // hit
  input wire logic        trap_o,                     // trap
  input wire logic [1:0]  trap_level_o,               // target
  input wire logic [5:0]  trap_class_o                // class
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  wire logic [1:0] lvl = current_exception_level_i;
  wire logic       act = hypervisor_level_active_i;
  wire logic       idt = hypervisor_id_group_trap_i;
  sequence id_read;
    rd_req_i && rd_op0_i == 2'h3 && rd_op1_i == 3'h0 && rd_crn_i == 4'h0
      && rd_crm_i == 4'h7 && rd_op2_i < 3'h3;
  endsequence
  req_answer_a:
    assert property (rd_req_i |=> rd_done_o) else $error("no answer");
  answer_cause_a:
    assert property (rd_done_o |-> $past(rd_req_i)) else $error("stray answer");
  user_trap_a:
    assert property (id_read ##0 lvl == 2'h0 |=> trap_o && trap_class_o == 6'h18
      && trap_level_o == ($past(act && hypervisor_general_exception_route_i)
      ? 2'h2 : 2'h1)) else $error("user read not trapped right");
  kernel_trap_a:
    assert property (id_read ##0 (lvl == 2'h1 && act && idt) |=> trap_o
      && trap_level_o == 2'h2) else $error("kernel read not trapped");
  kernel_ret_a:
    assert property (id_read ##0 (lvl == 2'h1 && !(act && idt)) |=> !trap_o
      && rd_hit_o) else $error("kernel read trapped");
  high_level_a:
    assert property (id_read ##0 lvl[1] |=> !trap_o) else $error("high trap");
  reg_value_a:
    assert property (id_read ##0 (lvl[1] && rd_op2_i < 3'h2) |=> rd_data_o ==
      ($past(rd_op2_i[0]) ? 64'h0000000010212122 : 64'h0000022200101122))
      else $error("wrong register value");
  trap_zero_a:
    assert property (rd_done_o && trap_o |-> rd_data_o == 64'h0)
      else $error("data on trap");
  hold_value_a:
    assert property (!rd_req_i |=> $stable(rd_data_o) && $stable(trap_o))
      else $error("answer changed without request");
  miss_clean_a:
    assert property (rd_done_o && !rd_hit_o |->
      !trap_o && rd_data_o == 64'h0) else $error("miss answered with data");
endmodule
bind mmid_bank mmid_bank_checker chk_u (.*);
`default_nettype wire

/* File: dv/mmid_pipe_model.sv */
// pipeline model: issues identification reads into the bank
`timescale 1ns/1ps
`default_nettype none
module mmid_pipe_model (
  input  wire logic        clk_sys_i, // clock
  output var  logic        rd_req_o,  // request
  output var  logic [15:0] enc_o      // op0 op1 crn crm op2
);
  initial begin
    rd_req_o = 1'b0;
    enc_o    = 16'h0000;
  end
  // encoding scrambled after release so no stale value looks valid
  task automatic issue(input logic [15:0] enc, input logic keep);
    rd_req_o = 1'b1;
    enc_o    = enc;
    @(negedge clk_sys_i);
    if (!keep) begin
      rd_req_o = 1'b0;
      enc_o    = ~enc;
    end
  endtask
endmodule
`default_nettype wire

/* File: dv/mmid_bank_tb_top.sv */
// self-checking bench for the identification register bank
`timescale 1ns/1ps
`default_nettype none
module mmid_bank_tb_top;
  localparam logic [63:0] R0 = {20'h0, 12'h222, 4'h0, 4'h0,
    4'h1, 4'h0, 4'h1, 4'h1, 4'h2, 4'h2};
  localparam logic [63:0] R1 = {32'h0, 4'h1, 4'h0, 4'h2, 4'h1,
    4'h2, 4'h1, 4'h2, 4'h2};
  localparam logic [63:0] R2 = 64'h0011001100100011;
  logic        clk_sys_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [1:0]  lvl = 2'h0;
  logic        act = 1'b0, rt = 1'b0, idt = 1'b0;
  logic        rd_req, done, hit, trp;
  logic [15:0] enc;
  logic [63:0] data;
  logic [1:0]  tlv;
  logic [5:0]  tcl;
  int          miscompares = 0, total_checks = 0, cyc = 0;
  always #50 clk_sys_i = ~clk_sys_i;
  mmid_pipe_model pipe_u (.clk_sys_i(clk_sys_i), .rd_req_o(rd_req),
    .enc_o(enc));
  mmid_bank #(.REG2_VALUE(R2)) dut_u (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .rd_req_i(rd_req),
    .rd_op0_i(enc[15:14]), .rd_op1_i(enc[13:11]), .rd_crn_i(enc[10:7]),
    .rd_crm_i(enc[6:3]), .rd_op2_i(enc[2:0]),
    .current_exception_level_i(lvl), .hypervisor_level_active_i(act),
    .hypervisor_general_exception_route_i(rt),
    .hypervisor_id_group_trap_i(idt), .rd_done_o(done), .rd_data_o(data),
    .rd_hit_o(hit), .trap_o(trp), .trap_level_o(tlv), .trap_class_o(tcl));
  task automatic check(input string nm, input logic [63:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic results;
    if (miscompares == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  function automatic logic [63:0] exp_data(input logic [2:0] op2, input logic ok);
    if (!ok) return 64'h0;
    return op2 == 3'h0 ? R0 : op2 == 3'h1 ? R1 : R2;
  endfunction
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      results;
    end
  end
  initial begin
    logic [15:0] e;
    logic        h, t, k;
    void'($urandom(45405));
    repeat (20) @(negedge clk_sys_i);
    rst_i = 1'b0;
    k = 1'b0;
    for (int i = 0; i < 400; i++) begin
      // kept request gives back-to-back reads with no idle cycle
      if (!k) @(negedge clk_sys_i);
      {lvl, act, rt, idt} = 5'($urandom);
      e = {2'h3, 3'h0, 4'h0, 3'h3, 1'($urandom), 3'($urandom)};
      if ($urandom % 8 == 0) e = 16'($urandom);
      k = ($urandom % 4 == 0);
      h = e[15:3] == {2'h3, 3'h0, 4'h0, 4'h7} && e[2:0] < 3'h3;
      t = h && (lvl == 2'h0 || (lvl == 2'h1 && act && idt));
      pipe_u.issue(e, k);
      check("done", done, 1'b1);
      check("hit", hit, h);
      check("trap", trp, t);
      check("class", tcl, t ? 6'h18 : 6'h0);
      check("data", data, exp_data(e[2:0], h && !t));
      if (t)
        check("level", tlv, (lvl == 2'h0 && !(act && rt)) ? 2'h1 : 2'h2);
    end
    results;
  end
endmodule
`default_nettype wire
